// [shared/slot_monitor_pkg.sv]
package slot_monitor_pkg;
	// ==========================================
	// Register indices and byte addresses
	localparam logic [7:0] IDX_COMMON_FOUR = 8'ha8;
	localparam logic [7:0] IDX_TX_MONITOR = 8'ha9;
	localparam logic [7:0] IDX_COMMON_FIVE = 8'haa;
	localparam logic [11:0] ADDR_COMMON_FOUR = {2'h0, IDX_COMMON_FOUR, 2'h0};
	localparam logic [11:0] ADDR_TX_MONITOR = {2'h0, IDX_TX_MONITOR, 2'h0};
	localparam logic [11:0] ADDR_COMMON_FIVE = {2'h0, IDX_COMMON_FIVE, 2'h0};
	localparam int ADDR_W = 12;
	// ==========================================
	// Field layout
	localparam int CH_W = 5;
	localparam int OCTET_W = 8;
	localparam int LOOP_BIT = 7;
	localparam int RX_ALIGN_BIT = 6;
	localparam int TX_ALIGN_BIT = 5;
	localparam int CH_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [4:0] CH_RESET = 5'h00;
	localparam logic [2:0] LAST_BIT_OF_SLOT = 3'h7;
	localparam int BIT_POS_W = 8;
	// ==========================================
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic [31:0] RDATA_ZERO = 32'h00000000;
endpackage

// [shared/slot_mon_if.sv]
`timescale 1ns/1ps
interface slot_mon_if;
	logic [4:0] sel;
	logic [7:0] octet;
	logic fresh;
	modport ctrl (output sel, input octet, input fresh);
	modport cap (input sel, output octet, output fresh);
endinterface

// [verilog/tx_slot_capture.sv]
`timescale 1ns/1ps
module tx_slot_capture (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Transmit bit stream
	input wire logic tx_bit,
	input wire logic tx_bit_en,
	input wire logic tx_frame_start,
	// Monitor link
	slot_mon_if.cap mon
);
	import slot_monitor_pkg::*;

	logic [BIT_POS_W-1:0] pos_r;
	logic [BIT_POS_W-1:0] pos_cur;
	logic [OCTET_W-2:0] shift_r;
	logic [OCTET_W-1:0] octet_r;
	logic fresh_r;
	logic hit;

	// Frame start marks bit 0 of slot 0
	assign pos_cur = tx_frame_start ? '0 : pos_r;
	assign hit = tx_bit_en && (pos_cur[BIT_POS_W-1:3] == mon.sel);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pos_r <= '0;
		end else if (tx_bit_en) begin
			pos_r <= pos_cur + 1'b1;
		end
	end

	// R5: first bit ends in MSB
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_r <= '0;
		end else if (hit) begin
			shift_r <= {shift_r[OCTET_W-3:0], tx_bit};
		end
	end

	// R9: refresh once per frame
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			octet_r <= CTRL_RESET;
			fresh_r <= 1'b0;
		end else begin
			fresh_r <= hit && (pos_cur[2:0] == LAST_BIT_OF_SLOT);
			if (hit && (pos_cur[2:0] == LAST_BIT_OF_SLOT)) begin
				octet_r <= {shift_r, tx_bit};
			end
		end
	end

	assign mon.octet = octet_r;
	assign mon.fresh = fresh_r;

	// R5: first bit enters shift head
	property p_first_bit_msb;
		@(posedge clk) disable iff (!rst_n)
		hit && pos_cur[2:0] == '0 |=> shift_r[0] == $past(tx_bit);
	endproperty
	a_first_bit_msb: assert property (p_first_bit_msb) // R5
		else $error("first slot bit not captured");
	// R9: refresh at last bit only
	property p_fresh_cause;
		@(posedge clk) disable iff (!rst_n)
		fresh_r |-> $past(hit) && $past(pos_cur[2:0]) == LAST_BIT_OF_SLOT;
	endproperty
	a_fresh_cause: assert property (p_fresh_cause) // R9
		else $error("monitor refreshed outside selected slot");
	// R5: octet holds shifted bits in order
	property p_octet_order;
		@(posedge clk) disable iff (!rst_n)
		fresh_r |-> octet_r[0] == $past(tx_bit)
			&& octet_r[7:1] == $past(shift_r);
	endproperty
	a_octet_order: assert property (p_octet_order) // R5
		else $error("monitor octet not in transmission order");
endmodule // tx_slot_capture

// [verilog/slot_monitor_loopback_ctrl.sv]
`timescale 1ns/1ps
// Notes on behaviour
// R1: Control four bit 7 enables remote loopback
// R2: Software writes zero to bits 6,5
// R3: Bits 4..0 pick transmit monitored slot
// R4: Selected transmit octet readable at A9
// R5: Bit 7 first sent, bit 0 last
// R6: Control five: rx align, tx align, channel
// R7: Align rising edge realigns if too close
// R8: Software toggles align after clock stable
// R9: Monitor refreshed every frame at slot
module slot_monitor_loopback_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Transmit bit stream
	input wire logic tx_bit,
	input wire logic tx_bit_en,
	input wire logic tx_frame_start,
	// Elastic store status
	input wire logic rx_store_close,
	input wire logic tx_store_close,
	// Control outputs
	output logic remote_loopback_en,
	output logic [slot_monitor_pkg::CH_W-1:0] rx_channel_select,
	output logic rx_store_realign,
	output logic tx_store_realign
);
	import slot_monitor_pkg::*;

	// ==========================================
	// Address decode
	typedef enum logic [1:0] {
		REG_NONE = 2'h0,
		REG_FOUR = 2'h1,
		REG_MON = 2'h3,
		REG_FIVE = 2'h2
	} reg_sel_t;

	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_COMMON_FOUR: decode = REG_FOUR;
			ADDR_TX_MONITOR: decode = REG_MON;
			ADDR_COMMON_FIVE: decode = REG_FIVE;
			default: decode = REG_NONE;
		endcase
	endfunction

	slot_mon_if mon ();

	logic loop_r;
	logic [CH_W-1:0] tx_sel_r;
	logic rx_align_r;
	logic tx_align_r;
	logic rx_align_prev_r;
	logic tx_align_prev_r;
	logic [CH_W-1:0] rx_sel_r;
	logic wr_pend_r;
	reg_sel_t wr_reg_r;
	logic [31:0] rdata_r;
	logic rdata_nxt;
	logic addr_phase;
	logic wr_four;
	logic wr_five;
	logic [7:0] four_val;
	logic [7:0] five_val;

	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign wr_four = wr_pend_r && (wr_reg_r == REG_FOUR);
	assign wr_five = wr_pend_r && (wr_reg_r == REG_FIVE);
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign rdata_nxt = addr_phase && !hwrite;

	// ==========================================
	// Bus slave state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_pend_r <= 1'b0;
			wr_reg_r <= REG_NONE;
		end else begin
			wr_pend_r <= addr_phase && hwrite;
			wr_reg_r <= decode(haddr[ADDR_W-1:0]);
		end
	end

	// Reserved bits read as zero
	assign four_val = {loop_r, 2'h0, tx_sel_r};
	assign five_val = {1'b0, rx_align_r, tx_align_r, rx_sel_r};

	// R4: monitor readable at A9
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_r <= RDATA_ZERO;
		end else if (rdata_nxt) begin
			case (decode(haddr[ADDR_W-1:0]))
				REG_FOUR: rdata_r <= {24'h000000, four_val};
				REG_MON: rdata_r <= {24'h000000, mon.octet};
				REG_FIVE: rdata_r <= {24'h000000, five_val};
				default: rdata_r <= RDATA_ZERO;
			endcase
		end
	end
	assign hrdata = rdata_r;

	// ==========================================
	// Common control four
	// R1: loopback bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loop_r <= CTRL_RESET[LOOP_BIT];
		end else if (wr_four) begin
			loop_r <= hwdata[LOOP_BIT];
		end
	end

	// R3: transmit slot select
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_sel_r <= CH_RESET;
		end else if (wr_four) begin
			tx_sel_r <= hwdata[CH_LSB +: CH_W];
		end
	end

	// ==========================================
	// Common control five
	// R6: align bits and rx select
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_align_r <= CTRL_RESET[RX_ALIGN_BIT];
			tx_align_r <= CTRL_RESET[TX_ALIGN_BIT];
			rx_sel_r <= CH_RESET;
		end else if (wr_five) begin
			rx_align_r <= hwdata[RX_ALIGN_BIT];
			tx_align_r <= hwdata[TX_ALIGN_BIT];
			rx_sel_r <= hwdata[CH_LSB +: CH_W];
		end
	end

	// R7: rising edge detect
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_align_prev_r <= 1'b0;
			tx_align_prev_r <= 1'b0;
		end else begin
			rx_align_prev_r <= rx_align_r;
			tx_align_prev_r <= tx_align_r;
		end
	end

	// R7: realign only if too close
	assign rx_store_realign = rx_align_r && !rx_align_prev_r
		&& rx_store_close;
	assign tx_store_realign = tx_align_r && !tx_align_prev_r
		&& tx_store_close;

	assign remote_loopback_en = loop_r;
	assign rx_channel_select = rx_sel_r;
	assign mon.sel = tx_sel_r;

	// ==========================================
	// Slot capture
	tx_slot_capture u_capture (
		.clk(clk),
		.rst_n(rst_n),
		.tx_bit(tx_bit),
		.tx_bit_en(tx_bit_en),
		.tx_frame_start(tx_frame_start),
		.mon(mon.cap)
	);

	// ==========================================
	// Checks
	property p_loop_write;
		@(posedge clk) disable iff (!rst_n)
		wr_four |=> remote_loopback_en == $past(hwdata[LOOP_BIT]);
	endproperty
	a_loop_write: assert property (p_loop_write) // R1
		else $error("loopback enable does not follow write");

	property p_loop_hold;
		@(posedge clk) disable iff (!rst_n)
		!wr_four |=> $stable(remote_loopback_en);
	endproperty
	a_loop_hold: assert property (p_loop_hold) // R1
		else $error("loopback enable changed without write");

	property p_sel_write;
		@(posedge clk) disable iff (!rst_n)
		wr_four |=> mon.sel == $past(hwdata[4:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) // R3
		else $error("transmit selector does not follow write");

	property p_mon_read;
		@(posedge clk) disable iff (!rst_n)
		rdata_nxt && haddr[ADDR_W-1:0] == ADDR_TX_MONITOR
		|=> hrdata == {24'h000000, $past(mon.octet)};
	endproperty
	a_mon_read: assert property (p_mon_read) // R4
		else $error("monitor read returned wrong octet");

	property p_five_read;
		@(posedge clk) disable iff (!rst_n)
		rdata_nxt && haddr[ADDR_W-1:0] == ADDR_COMMON_FIVE
		|=> hrdata[7] == 1'b0 && hrdata[4:0] == rx_channel_select;
	endproperty
	a_five_read: assert property (p_five_read) // R6
		else $error("control five read back wrong");

	property p_rx_realign;
		@(posedge clk) disable iff (!rst_n)
		wr_five && hwdata[RX_ALIGN_BIT] && !rx_align_r
		##1 rx_store_close |-> rx_store_realign ##1 !rx_store_realign;
	endproperty
	a_rx_realign: assert property (p_rx_realign) // R7
		else $error("receive realign not a single pulse");

	property p_tx_realign_cause;
		@(posedge clk) disable iff (!rst_n)
		tx_store_realign |-> tx_store_close && $rose(tx_align_r);
	endproperty
	a_tx_realign_cause: assert property (p_tx_realign_cause) // R7
		else $error("transmit realign without rising command");

	property p_mon_stable;
		@(posedge clk) disable iff (!rst_n)
		!mon.fresh |-> $stable(mon.octet);
	endproperty
	a_mon_stable: assert property (p_mon_stable) // R9
		else $error("monitor octet changed without refresh");

	property p_ready;
		@(posedge clk) disable iff (!rst_n)
		hreadyout && hresp == HRESP_OKAY;
	endproperty
	a_ready: assert property (p_ready) // R4
		else $error("slave not ready or not okay");
endmodule // slot_monitor_loopback_ctrl

// [verif/slot_monitor_loopback_ctrl_test.sv]
`timescale 1ns/1ps
module slot_monitor_loopback_ctrl_test;
	import slot_monitor_pkg::*;
	// ==========================================
	// Signals
	logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
	logic tx_bit, tx_bit_en, tx_frame_start;
	logic rx_store_close, tx_store_close, remote_loopback_en;
	logic rx_store_realign, tx_store_realign;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, al;
	logic [2:0] hsize;
	logic [4:0] rx_channel_select, ch;
	logic [7:0] oct [32];
	int error_cnt, n_compared;
	assign hready = hreadyout;

	slot_monitor_loopback_ctrl u_dut (
		.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata,
		.tx_bit, .tx_bit_en, .tx_frame_start,
		.rx_store_close, .tx_store_close,
		.remote_loopback_en, .rx_channel_select,
		.rx_store_realign, .tx_store_realign
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ==========================================
	// Expectations
	function automatic logic [7:0] ctl4(input logic lb, input logic [4:0] c);
		return {lb, 2'b00, c};
	endfunction

	function automatic logic [7:0] ctl5(input logic [1:0] a, input logic [4:0] c);
		return {1'b0, a, c};
	endfunction

	// ==========================================
	// Reporting
	task automatic check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end

	// ==========================================
	// Bus and stream drivers
	task automatic wait_rdy;
		do begin
			@(posedge clk);
		end while (hready !== 1'b1);
	endtask

	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_rdy();
		rd = hrdata;
		check("hresp", 32'(hresp), 32'(HRESP_OKAY));
	endtask

	task automatic send_frame;
		for (int s = 0; s < 32; s++) oct[s] = 8'($urandom);
		for (int i = 0; i < 256; i++) begin
			@(posedge clk);
			if ($urandom % 4 == 0) begin
				tx_bit_en <= 1'b0;
				@(posedge clk);
			end
			tx_bit_en <= 1'b1;
			tx_frame_start <= (i == 0);
			tx_bit <= oct[i / 8][7 - i % 8];
		end
		@(posedge clk);
		tx_bit_en <= 1'b0;
		tx_frame_start <= 1'b0;
	endtask

	// ==========================================
	// Tests
	initial begin
		{rst_n, hsel, hwrite, tx_bit, tx_bit_en, tx_frame_start} = '0;
		{rx_store_close, tx_store_close} = '0;
		haddr = '0;
		hwdata = '0;
		htrans = '0;
		hsize = 3'h2;
		void'($urandom(32'h3efa749b));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		xfer(1'b0, ADDR_COMMON_FOUR, 8'h00);
		check("control four reset", rd, 32'h0);
		xfer(1'b0, ADDR_COMMON_FIVE, 8'h00);
		check("control five reset", rd, 32'h0);
		xfer(1'b0, ADDR_TX_MONITOR, 8'h00);
		check("monitor reset", rd, 32'h0);
		check("loopback reset", 32'(remote_loopback_en), 32'h0);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			ch = (k == 0) ? 5'h00 : (k == 1) ? 5'h1f : 5'($urandom);
			xfer(1'b1, ADDR_COMMON_FOUR, ctl4(k[0], ch));
			#1;
			check("loopback", 32'(remote_loopback_en), 32'(k[0]));
			xfer(1'b0, ADDR_COMMON_FOUR, 8'h00);
			check("control four", rd, 32'(ctl4(k[0], ch)));
			repeat (2) begin
				send_frame();
				xfer(1'b0, ADDR_TX_MONITOR, 8'h00);
				check("monitor", rd, 32'(oct[ch]));
			end
			xfer(1'b1, ADDR_TX_MONITOR, ~oct[ch]);
			xfer(1'b0, ADDR_TX_MONITOR, 8'h00);
			check("monitor ro", rd, 32'(oct[ch]));
		end
		xfer(1'b0, 12'h100, 8'h00);
		check("unmapped", rd, 32'h0);
		$display("test monitor done");
		for (int k = 0; k < 8; k++) begin
			ch = 5'($urandom);
			al = (k < 4) ? 2'b11 : 2'($urandom);
			xfer(1'b1, ADDR_COMMON_FIVE, 8'h00);
			rx_store_close <= k[0];
			tx_store_close <= k[1];
			xfer(1'b1, ADDR_COMMON_FIVE, ctl5(al, ch));
			#1;
			check("rx realign", 32'(rx_store_realign),
				32'(al[1] & k[0]));
			check("tx realign", 32'(tx_store_realign),
				32'(al[0] & k[1]));
			check("rx channel", 32'(rx_channel_select), 32'(ch));
			@(posedge clk);
			#1;
			check("rx pulse end", 32'(rx_store_realign), 32'h0);
			check("tx pulse end", 32'(tx_store_realign), 32'h0);
			xfer(1'b1, ADDR_COMMON_FIVE, ctl5(al, ch));
			#1;
			check("rx no repeat", 32'(rx_store_realign), 32'h0);
			check("tx no repeat", 32'(tx_store_realign), 32'h0);
			xfer(1'b0, ADDR_COMMON_FIVE, 8'h00);
			check("control five", rd, 32'(ctl5(al, ch)));
		end
		$display("test realign done");
		stop_test();
	end
endmodule // slot_monitor_loopback_ctrl_test
